//--- verilog/fcdma_defs.svh
`ifndef FCDMA_DEFS_SVH
`define FCDMA_DEFS_SVH

// Host register offsets on the low address lines.
`define FCD_OFF_CMD    4'h8
`define FCD_OFF_REQ    4'h9
`define FCD_OFF_MSK1   4'ha
`define FCD_OFF_MODE   4'hb
`define FCD_OFF_CLRPTR 4'hc
`define FCD_OFF_MCLR   4'hd
`define FCD_OFF_CLRMSK 4'he
`define FCD_OFF_MSKALL 4'hf

// Command register bit positions.
`define FCD_CMD_M2M   0
`define FCD_CMD_DIS   2
`define FCD_CMD_REQLO 6
`define FCD_CMD_ACKHI 7

// Channel mode field positions and encodings.
`define FCD_MODE_TYPE 1:0
`define FCD_MODE_AUTO 2
`define FCD_MODE_DEC  3
`define FCD_MODE_SVC  5:4
`define FCD_TYPE_TOMEM   2'h1
`define FCD_TYPE_FROMMEM 2'h2
`define FCD_SVC_DEMAND   2'h0
`define FCD_SVC_SINGLE   2'h1
`define FCD_SVC_BLOCK    2'h2
`define FCD_SVC_CASC     2'h3

// Reset values.
`define FCD_CMD_RST  8'h00
`define FCD_MASK_RST 4'hf
`define FCD_MODE_RST 6'h00
`define FCD_W16_RST  16'h0000

// Least strobe length in clocks, covering the two-stage input sampling.
`define FCD_XFER_CYC 2'h3

`endif

//--- verilog/fcdma_pkg.sv
package fcdma_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HOLD,
    ST_ADDR,
    ST_XFER,
    ST_FIN,
    ST_CASC
  } fcdma_state_t;

endpackage

//--- verilog/fcdma_top.sv
`timescale 1ns/1ps
`include "fcdma_defs.svh"
module fcdma_top
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       cs_n,
  input  wire logic       ready,
  input  wire logic       bus_grant_in,
  output logic            bus_request_out,
  input  wire logic [3:0] channel_request,
  output logic      [3:0] channel_acknowledge,
  input  wire logic [7:0] host_data_bus_in,
  output logic      [7:0] host_data_bus_out,
  output logic            host_data_bus_oe,
  input  wire logic       io_read_strobe_n_in,
  output logic            io_read_strobe_n_out,
  output logic            io_read_strobe_n_oe,
  input  wire logic       io_write_strobe_n_in,
  output logic            io_write_strobe_n_out,
  output logic            io_write_strobe_n_oe,
  input  wire logic       end_of_process_line_n_in,
  output logic            end_of_process_line_n_out,
  output logic            end_of_process_line_n_oe,
  input  wire logic [3:0] low_address_lines_in,
  output logic      [3:0] low_address_lines_out,
  output logic            low_address_lines_oe,
  output logic      [3:0] mid_address_lines,
  output logic            upper_address_strobe,
  output logic            address_latch_enable,
  output logic            memory_read_strobe_n,
  output logic            memory_write_strobe_n
);

  function automatic logic [1:0] fcdma_prio(input logic [3:0] p);
    fcdma_prio = p[0] ? 2'h0 : p[1] ? 2'h1 : p[2] ? 2'h2 : 2'h3;
  endfunction

  function automatic logic [15:0] fcdma_step(input logic [15:0] v, input logic dn);
    fcdma_step = dn ? v - 16'h0001 : v + 16'h0001;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Every pin input but clk_sys and rst passes two flip-flops before use.

  logic [21:0] pin_s1_r;
  logic [21:0] pin_s2_r;
  logic        ior_d_r;
  logic        iow_d_r;

  always_ff @(posedge clk_sys)
  begin
    pin_s1_r <= {cs_n, io_read_strobe_n_in, io_write_strobe_n_in, ready, bus_grant_in,
                 end_of_process_line_n_in, channel_request, low_address_lines_in,
                 host_data_bus_in};
    pin_s2_r <= pin_s1_r;
  end

  wire       cs_s    = pin_s2_r[21];
  wire       ior_s   = pin_s2_r[20];
  wire       iow_s   = pin_s2_r[19];
  wire       ready_s = pin_s2_r[18];
  wire       grant_s = pin_s2_r[17];
  wire       eop_s   = pin_s2_r[16];
  wire [3:0] dreq_s  = pin_s2_r[15:12];
  wire [3:0] a_s     = pin_s2_r[11:8];
  wire [7:0] db_s    = pin_s2_r[7:0];

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ior_d_r <= 1'b1;
      iow_d_r <= 1'b1;
    end
    else
    begin
      ior_d_r <= ior_s;
      iow_d_r <= iow_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state.

  logic [15:0]             base_addr_r [4];
  logic [15:0]             base_cnt_r  [4];
  logic [15:0]             cur_addr_r  [4];
  logic [15:0]             cur_cnt_r   [4];
  logic [5:0]              mode_r      [4];
  logic [7:0]              cmd_r;
  logic [3:0]              tc_st_r;
  logic [3:0]              soft_req_r;
  logic [3:0]              mask_r;
  logic [7:0]              temp_r;
  logic                    ptr_r;
  logic [7:0]              rd_data_r;
  fcdma_pkg::fcdma_state_t state_r;
  fcdma_pkg::fcdma_state_t state_nxt;
  logic [1:0]              sel_r;
  logic                    m2m_r;
  logic                    phase_r;
  logic [1:0]              xcnt_r;
  logic                    eop_seen_r;
  logic                    term_r;
  logic                    tc_r;

  ////////////////////////////////////////////////////////////////////////////
  // Request and host decode.

  wire [3:0] dreq_act = cmd_r[`FCD_CMD_REQLO] ? ~dreq_s : dreq_s;
  wire [3:0] pend     = (dreq_act & ~mask_r) | soft_req_r;
  wire       m2m_go   = cmd_r[`FCD_CMD_M2M] & soft_req_r[0];
  wire [1:0] pick     = fcdma_prio(pend);
  wire       idle     = state_r == fcdma_pkg::ST_IDLE;
  // Chip select only counts in the idle cycle with the bus released.
  wire       host_ok  = idle & ~cs_s & ~grant_s;
  wire       wr_edge  = host_ok & iow_s & ~iow_d_r;
  wire       rd_edge  = host_ok & ior_s & ~ior_d_r;
  wire       host_rd  = host_ok & ~ior_s;
  wire       is_w16   = ~a_s[3];
  wire [1:0] hch      = a_s[2:1];
  wire       wr16     = wr_edge & is_w16;
  wire       wr_reg   = wr_edge & a_s[3];
  wire       mclr     = wr_reg & (a_s == `FCD_OFF_MCLR);

  wire [15:0] hsel16 = a_s[0] ? cur_cnt_r[hch] : cur_addr_r[hch];
  wire [7:0]  hbyte  = ptr_r ? hsel16[15:8] : hsel16[7:0];
  wire [7:0]  rd_mux = is_w16 ? hbyte :
                       (a_s == `FCD_OFF_CMD)  ? {dreq_act | soft_req_r, tc_st_r} :
                       (a_s == `FCD_OFF_MCLR) ? temp_r : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Working channel and transfer decode.

  wire [1:0]  wch     = m2m_r ? {1'b0, phase_r} : sel_r;
  wire [1:0]  cch     = m2m_r ? 2'h1 : sel_r;
  wire [5:0]  wmode   = mode_r[wch];
  wire [15:0] waddr   = cur_addr_r[wch];
  wire [1:0]  wtype   = wmode[`FCD_MODE_TYPE];
  wire [1:0]  svc_md  = mode_r[sel_r][`FCD_MODE_SVC];
  wire        st_addr = state_r == fcdma_pkg::ST_ADDR;
  wire        st_xfer = state_r == fcdma_pkg::ST_XFER;
  wire        st_fin  = state_r == fcdma_pkg::ST_FIN;
  wire        svc     = st_addr | st_xfer | st_fin;
  wire        owned   = svc | (state_r == fcdma_pkg::ST_CASC);
  wire        last    = ~m2m_r | phase_r;
  // Ready is sampled late, so a slow memory must hold ready low early enough.
  wire        x_done  = st_xfer & (xcnt_r == `FCD_XFER_CYC - 2'h1) & ready_s;
  wire        cnt0    = cur_cnt_r[cch] == 16'h0000;
  wire        ext_eop = svc & ~eop_s;
  wire [3:0]  own     = m2m_r ? 4'h3 : 4'h1 << sel_r;
  wire        mem_rd  = st_xfer & (m2m_r ? ~phase_r : wtype == `FCD_TYPE_FROMMEM);
  wire        mem_wr  = st_xfer & (m2m_r ? phase_r : wtype == `FCD_TYPE_TOMEM);
  wire        io_rd   = st_xfer & ~m2m_r & (wtype == `FCD_TYPE_TOMEM);
  wire        io_wr   = st_xfer & ~m2m_r & (wtype == `FCD_TYPE_FROMMEM);

  ////////////////////////////////////////////////////////////////////////////
  // Service sequencer.

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      fcdma_pkg::ST_IDLE:
        if (!cmd_r[`FCD_CMD_DIS] && (pend != 4'h0) && !grant_s)
          state_nxt = fcdma_pkg::ST_HOLD;
      fcdma_pkg::ST_HOLD:
        if (!m2m_r && !pend[sel_r])
          state_nxt = fcdma_pkg::ST_IDLE;
        else if (grant_s)
          state_nxt = (!m2m_r && svc_md == `FCD_SVC_CASC) ?
                      fcdma_pkg::ST_CASC : fcdma_pkg::ST_ADDR;
      fcdma_pkg::ST_ADDR:
        state_nxt = fcdma_pkg::ST_XFER;
      fcdma_pkg::ST_XFER:
        if (x_done)
          state_nxt = last ? fcdma_pkg::ST_FIN : fcdma_pkg::ST_ADDR;
      fcdma_pkg::ST_FIN:
        if (term_r || !grant_s)
          state_nxt = fcdma_pkg::ST_IDLE;
        else if (m2m_r || svc_md == `FCD_SVC_BLOCK)
          state_nxt = fcdma_pkg::ST_ADDR;
        else if (svc_md == `FCD_SVC_DEMAND && dreq_act[sel_r])
          state_nxt = fcdma_pkg::ST_ADDR;
        else
          state_nxt = fcdma_pkg::ST_IDLE;
      fcdma_pkg::ST_CASC:
        if (!pend[sel_r] || !grant_s)
          state_nxt = fcdma_pkg::ST_IDLE;
      default:
        state_nxt = fcdma_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || mclr)
    begin
      state_r    <= fcdma_pkg::ST_IDLE;
      sel_r      <= 2'h0;
      m2m_r      <= 1'b0;
      phase_r    <= 1'b0;
      xcnt_r     <= 2'h0;
      eop_seen_r <= 1'b0;
      term_r     <= 1'b0;
      tc_r       <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      xcnt_r  <= (st_xfer && !x_done && xcnt_r != `FCD_XFER_CYC - 2'h1) ?
                 xcnt_r + 2'h1 : (st_xfer ? xcnt_r : 2'h0);
      if (idle)
      begin
        sel_r      <= m2m_go ? 2'h0 : pick;
        m2m_r      <= m2m_go;
        phase_r    <= 1'b0;
        eop_seen_r <= 1'b0;
      end
      else if (ext_eop)
        eop_seen_r <= 1'b1;
      if (x_done)
      begin
        phase_r <= ~phase_r & m2m_r;
        tc_r    <= last & cnt0;
        term_r  <= (last & cnt0) | eop_seen_r | ext_eop;
      end
      else if (st_addr)
      begin
        tc_r   <= 1'b0;
        term_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file: host programming and channel updates.

  always_ff @(posedge clk_sys)
  begin
    if (rst || mclr)
    begin
      cmd_r      <= `FCD_CMD_RST;
      tc_st_r    <= 4'h0;
      soft_req_r <= 4'h0;
      mask_r     <= `FCD_MASK_RST;
      temp_r     <= 8'h00;
      ptr_r      <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
        base_addr_r[i] <= `FCD_W16_RST;
        base_cnt_r[i]  <= `FCD_W16_RST;
        cur_addr_r[i]  <= `FCD_W16_RST;
        cur_cnt_r[i]   <= `FCD_W16_RST;
        mode_r[i]      <= `FCD_MODE_RST;
      end
    end
    else
    begin
      if (wr_edge || rd_edge)
      begin
        if (is_w16)
          ptr_r <= ~ptr_r;
        else if (wr_edge && a_s == `FCD_OFF_CLRPTR)
          ptr_r <= 1'b0;
      end
      if (rd_edge && a_s == `FCD_OFF_CMD)
        tc_st_r <= 4'h0;
      if (wr16 && !a_s[0])
      begin
        if (ptr_r)
        begin
          base_addr_r[hch][15:8] <= db_s;
          cur_addr_r[hch][15:8]  <= db_s;
        end
        else
        begin
          base_addr_r[hch][7:0] <= db_s;
          cur_addr_r[hch][7:0]  <= db_s;
        end
      end
      if (wr16 && a_s[0])
      begin
        if (ptr_r)
        begin
          base_cnt_r[hch][15:8] <= db_s;
          cur_cnt_r[hch][15:8]  <= db_s;
        end
        else
        begin
          base_cnt_r[hch][7:0] <= db_s;
          cur_cnt_r[hch][7:0]  <= db_s;
        end
      end
      if (wr_reg)
      begin
        case (a_s)
          `FCD_OFF_CMD:    cmd_r <= db_s;
          `FCD_OFF_REQ:    soft_req_r[db_s[1:0]] <= db_s[2];
          `FCD_OFF_MSK1:   mask_r[db_s[1:0]] <= db_s[2];
          `FCD_OFF_MODE:   mode_r[db_s[1:0]] <= db_s[7:2];
          `FCD_OFF_CLRMSK: mask_r <= 4'h0;
          `FCD_OFF_MSKALL: mask_r <= db_s[3:0];
          default:         ;
        endcase
      end
      if (x_done && m2m_r && !phase_r)
        temp_r <= db_s;
      if (x_done)
      begin
        cur_addr_r[wch] <= fcdma_step(waddr, wmode[`FCD_MODE_DEC]);
        if (last)
          cur_cnt_r[cch] <= fcdma_step(cur_cnt_r[cch], 1'b1);
      end
      if (st_fin && term_r)
      begin
        for (int i = 0; i < 4; i++)
        begin
          if (own[i])
          begin
            tc_st_r[i]    <= 1'b1;
            soft_req_r[i] <= 1'b0;
            if (mode_r[i][`FCD_MODE_AUTO])
            begin
              cur_addr_r[i] <= base_addr_r[i];
              cur_cnt_r[i]  <= base_cnt_r[i];
            end
            else
              mask_r[i] <= 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rd_data_r <= 8'h00;
    else
      rd_data_r <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive. Outputs stay released outside service so the host owns them, except the data bus during a host read.

  wire [3:0] ack_on = owned ? (4'h1 << sel_r) : 4'h0;

  assign bus_request_out           = ~idle;
  assign channel_acknowledge       = cmd_r[`FCD_CMD_ACKHI] ? ack_on : ~ack_on;
  assign upper_address_strobe      = st_addr;
  assign address_latch_enable      = svc;
  assign low_address_lines_out     = waddr[3:0];
  assign low_address_lines_oe      = svc;
  assign mid_address_lines         = waddr[7:4];
  assign host_data_bus_oe          = host_rd | st_addr | (st_xfer & m2m_r & phase_r);
  assign host_data_bus_out         = host_rd ? rd_data_r : st_addr ? waddr[15:8] : temp_r;
  assign memory_read_strobe_n      = ~mem_rd;
  assign memory_write_strobe_n     = ~mem_wr;
  assign io_read_strobe_n_out      = ~io_rd;
  assign io_read_strobe_n_oe       = svc;
  assign io_write_strobe_n_out     = ~io_wr;
  assign io_write_strobe_n_oe      = svc;
  assign end_of_process_line_n_out = 1'b0;
  assign end_of_process_line_n_oe  = st_fin & tc_r;

endmodule

//--- testbench/fcdma_properties.sv
`timescale 1ns/1ps
module fcdma_properties
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       ready,
  input wire logic       bus_request_out,
  input wire logic [3:0] channel_acknowledge,
  input wire logic       host_data_bus_oe,
  input wire logic       low_address_lines_oe,
  input wire logic       upper_address_strobe,
  input wire logic       address_latch_enable,
  input wire logic       memory_read_strobe_n,
  input wire logic       memory_write_strobe_n,
  input wire logic       end_of_process_line_n_out,
  input wire logic       end_of_process_line_n_oe,
  input wire logic       io_read_strobe_n_oe,
  input wire logic       io_read_strobe_n_out,
  input wire logic       io_write_strobe_n_oe,
  input wire logic       io_write_strobe_n_out
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  // Both polarities are accepted so a reprogrammed acknowledge level stays legal.
  a_ack_one_only:
    assert property ($onehot0(channel_acknowledge) || $onehot0(~channel_acknowledge))
    else $error("More than one channel acknowledge active.");
  a_ack_needs_bus:
    assert property (!bus_request_out |-> channel_acknowledge inside {4'h0, 4'hf})
    else $error("Acknowledge active without the bus.");
  a_strobe_pulse:
    assert property (upper_address_strobe |-> address_latch_enable && host_data_bus_oe
                     && low_address_lines_oe ##1 !upper_address_strobe)
    else $error("Upper address strobe malformed.");
  a_aen_opens:
    assert property ($rose(address_latch_enable) |-> upper_address_strobe && bus_request_out)
    else $error("Service began without an address phase.");
  a_lines_in_idle:
    assert property (low_address_lines_oe |-> address_latch_enable)
    else $error("Low address lines driven outside service.");
  a_eop_pulse:
    assert property (end_of_process_line_n_oe |-> !end_of_process_line_n_out
                     ##1 !end_of_process_line_n_oe)
    else $error("End of process pulse malformed.");
  a_mem_strobes:
    assert property (!memory_read_strobe_n || !memory_write_strobe_n |-> address_latch_enable
                     && !upper_address_strobe && (memory_read_strobe_n || memory_write_strobe_n))
    else $error("Memory strobe outside a transfer.");
  // Both lines are driven in service; only one of them may be pulled low.
  a_io_drive:
    assert property (io_read_strobe_n_oe || io_write_strobe_n_oe |-> address_latch_enable
                     && (io_read_strobe_n_out || io_write_strobe_n_out))
    else $error("I/O strobe driven outside service.");
  a_ready_stretch:
    assert property (!ready [*4] ##0 (!memory_read_strobe_n || !memory_write_strobe_n)
                     |=> !memory_read_strobe_n || !memory_write_strobe_n)
    else $error("Strobe ended while not ready.");
  a_aen_holds_req:
    assert property (address_latch_enable |-> bus_request_out)
    else $error("Bus request dropped in service.");

  c_service: cover property ($rose(address_latch_enable));
  c_eop: cover property (end_of_process_line_n_oe);
  c_stall: cover property (!memory_read_strobe_n && !ready);
  c_copy: cover property (!memory_write_strobe_n && host_data_bus_oe);
endmodule

//--- testbench/fcdma_host_model.sv
`timescale 1ns/1ps
module fcdma_host_model
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       slow,
  input  wire logic       bus_request_out,
  input  wire logic       memory_read_strobe_n,
  input  wire logic       io_read_strobe_n_out,
  input  wire logic       io_read_strobe_n_oe,
  input  wire logic [3:0] low_address_lines_out,
  output logic            bus_grant_in,
  output logic            ready,
  output logic            far_drive,
  output logic      [7:0] far_data
);
  logic [3:0] wait_r = 4'h0;
  logic [3:0] cyc_r  = 4'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // The host finishes its own bus cycle first, so the grant lags the request.
  always_ff @(posedge clk_sys)
  begin
    cyc_r <= cyc_r + 4'h1;
    if (rst || !bus_request_out)
    begin
      wait_r       <= 4'h0;
      bus_grant_in <= 1'b0;
    end
    else if (wait_r == (slow ? 4'h6 : 4'h1))
      bus_grant_in <= 1'b1;
    else
      wait_r <= wait_r + 4'h1;
  end

  // A slow memory is ready only half the time, in runs of eight cycles.
  assign ready     = !slow || cyc_r[3];
  assign far_drive = !memory_read_strobe_n || (io_read_strobe_n_oe && !io_read_strobe_n_out);
  assign far_data  = {4'h5, low_address_lines_out};
endmodule

//--- testbench/tb.sv
`timescale 1ns/1ps
`include "fcdma_defs.svh"
module tb;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        cs_n = 1'b1;
  logic        ior_n = 1'b1;
  logic        iow_n = 1'b1;
  logic        host_drv = 1'b0;
  logic        rd_take = 1'b0;
  logic        slow = 1'b1;
  logic [3:0]  reg_sel = 4'h0;
  logic [7:0]  host_data = 8'h00;
  logic [3:0]  channel_request = 4'h0;
  logic [31:0] lfsr = 32'h38ed;
  logic [15:0] a0, a1, exp_a;
  logic [15:0] eop_cnt = 16'h0;
  logic [15:0] wr_seen = 16'h0;
  logic [15:0] rd_seen = 16'h0;
  logic [7:0]  q_rd[$];
  logic [15:0] q_addr[$];
  logic [7:0]  q_wd[$];
  logic        memory_write_strobe_d = 1'b1;
  int          bad_count = 0;
  int          n_tests = 0;
  logic        ready, bus_grant_in, bus_request_out, far_drive, host_data_bus_oe;
  logic        io_read_strobe_n_out, io_read_strobe_n_oe, io_write_strobe_n_out;
  logic        io_write_strobe_n_oe, end_of_process_line_n_out, end_of_process_line_n_oe;
  logic        low_address_lines_oe, upper_address_strobe, address_latch_enable;
  logic        memory_read_strobe_n, memory_write_strobe_n;
  logic [3:0]  channel_acknowledge, low_address_lines_out, mid_address_lines;
  logic [7:0]  far_data, host_data_bus_out;
  wire  [7:0]  host_data_bus_in;
  wire         io_read_strobe_n_in, io_write_strobe_n_in, end_of_process_line_n_in;
  wire  [3:0]  low_address_lines_in;

  always #5 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////////
  // An undriven data bus shows the inverse of the host's last byte, never a stale match.
  assign host_data_bus_in = host_data_bus_oe ? host_data_bus_out : far_drive ? far_data
                            : host_drv ? host_data : ~host_data;
  assign io_read_strobe_n_in = io_read_strobe_n_oe ? io_read_strobe_n_out : ior_n;
  assign io_write_strobe_n_in = io_write_strobe_n_oe ? io_write_strobe_n_out : iow_n;
  assign end_of_process_line_n_in = end_of_process_line_n_oe ? end_of_process_line_n_out : 1'b1;
  assign low_address_lines_in = low_address_lines_oe ? low_address_lines_out : reg_sel;

  fcdma_top dut_u (.clk_sys, .rst, .cs_n, .ready, .bus_grant_in, .bus_request_out,
    .channel_request, .channel_acknowledge, .host_data_bus_in, .host_data_bus_out,
    .host_data_bus_oe, .io_read_strobe_n_in, .io_read_strobe_n_out, .io_read_strobe_n_oe,
    .io_write_strobe_n_in, .io_write_strobe_n_out, .io_write_strobe_n_oe,
    .end_of_process_line_n_in, .end_of_process_line_n_out, .end_of_process_line_n_oe,
    .low_address_lines_in, .low_address_lines_out, .low_address_lines_oe, .mid_address_lines,
    .upper_address_strobe, .address_latch_enable, .memory_read_strobe_n,
    .memory_write_strobe_n);

  fcdma_host_model host_u (.clk_sys, .rst, .slow, .bus_request_out, .memory_read_strobe_n,
    .io_read_strobe_n_out, .io_read_strobe_n_oe, .low_address_lines_out, .bus_grant_in,
    .ready, .far_drive, .far_data);

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic give_verdict();
    if (q_rd.size() != 0 || q_addr.size() != 0 || q_wd.size() != 0)
      bad_count++;
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic compare(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic compare_addr(input logic [15:0] got, input logic [15:0] exp);
    compare(got, exp);
  endtask

  task automatic compare_byte(input logic [7:0] got, input logic [7:0] exp);
    compare({8'h00, got}, {8'h00, exp});
  endtask

  // Each byte gets its own strobe edge; chip select stays low across it.
  task automatic host_wr(input logic [3:0] a, input logic [7:0] d);
    cs_n = 1'b0;
    reg_sel = a;
    host_data = d;
    host_drv = 1'b1;
    iow_n = 1'b0;
    tick(4);
    iow_n = 1'b1;
    tick(4);
    cs_n = 1'b1;
    host_drv = 1'b0;
    tick(1);
  endtask

  task automatic host_rd(input logic [3:0] a, input logic [7:0] d);
    q_rd.push_back(d);
    cs_n = 1'b0;
    reg_sel = a;
    ior_n = 1'b0;
    tick(6);
    rd_take = 1'b1;
    tick(1);
    rd_take = 1'b0;
    ior_n = 1'b1;
    tick(4);
    cs_n = 1'b1;
    tick(1);
  endtask

  task automatic wait_for(input logic sel);
    int n = 0;
    while (sel ? !(q_addr.size() == 0 && bus_request_out === 1'b0)
           : channel_acknowledge !== 4'hd)
    begin
      n++;
      if (n > 3000)
      begin
        $display("Error at %0t: wait ran out", $time);
        bad_count++;
        give_verdict();
      end
      tick(1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys)
  begin
    if (upper_address_strobe === 1'b1)
    begin
      exp_a = (q_addr.size() != 0) ? q_addr.pop_front() : 16'hxxxx;
      compare_addr({host_data_bus_out, mid_address_lines, low_address_lines_out}, exp_a);
    end
    if (rd_take === 1'b1)
      compare_byte(host_data_bus_oe === 1'b1 ? host_data_bus_out : 8'hxx,
                   (q_rd.size() != 0) ? q_rd.pop_front() : 8'hxx);
    // The copied byte is checked once, in the first cycle of each write half.
    if (!memory_write_strobe_n && memory_write_strobe_d && host_data_bus_oe === 1'b1)
      compare_byte(host_data_bus_out, (q_wd.size() != 0) ? q_wd.pop_front() : 8'hxx);
    memory_write_strobe_d <= memory_write_strobe_n;
    if (end_of_process_line_n_oe === 1'b1)
      eop_cnt <= eop_cnt + 16'h1;
    if (!memory_write_strobe_n && io_read_strobe_n_oe && !io_read_strobe_n_out)
      wr_seen <= wr_seen + 16'h1;
    if (!memory_read_strobe_n && io_write_strobe_n_oe && !io_write_strobe_n_out)
      rd_seen <= rd_seen + 16'h1;
  end

  initial
  begin
    tick(4);
    rst = 1'b0;
    tick(3);
    host_rd(`FCD_OFF_CMD, 8'h00);
    host_rd(`FCD_OFF_MCLR, 8'h00);
    lfsr = lfsr_next(lfsr_next(lfsr));
    a0 = lfsr[15:0];
    lfsr = lfsr_next(lfsr_next(lfsr));
    a1 = {lfsr[15:8], 8'hff};
    host_wr(4'h0, a0[7:0]);
    host_wr(4'h0, a0[15:8]);
    host_wr(`FCD_OFF_CLRPTR, 8'h00);
    host_rd(4'h0, a0[7:0]);
    host_rd(4'h0, a0[15:8]);
    host_wr(4'h1, 8'h00);
    host_wr(4'h1, 8'h00);
    host_wr(4'h2, a1[7:0]);
    host_wr(4'h2, a1[15:8]);
    host_wr(4'h3, 8'h01);
    host_wr(4'h3, 8'h00);
    host_wr(`FCD_OFF_MODE, 8'h44);
    host_wr(`FCD_OFF_MODE, 8'h99);
    channel_request = 4'h3;
    tick(20);
    compare({15'h0, bus_request_out}, 16'h0);
    q_addr.push_back(a0);
    q_addr.push_back(a1);
    q_addr.push_back(a1 + 16'h1);
    host_wr(`FCD_OFF_CLRMSK, 8'h00);
    wait_for(1'b0);
    channel_request = 4'h1;
    wait_for(1'b1);
    tick(20);
    compare({15'h0, bus_request_out}, 16'h0);
    compare(eop_cnt, 16'h2);
    compare(16'(wr_seen != 16'h0), 16'h1);
    compare(16'(rd_seen != 16'h0), 16'h1);
    channel_request = 4'h0;
    host_rd(`FCD_OFF_CMD, 8'h03);
    host_rd(`FCD_OFF_CMD, 8'h00);
    slow = 1'b0;
    q_addr.push_back(a1);
    q_addr.push_back(a1 + 16'h1);
    channel_request = 4'h2;
    wait_for(1'b0);
    channel_request = 4'h0;
    wait_for(1'b1);
    tick(4);
    compare(eop_cnt, 16'h3);
    // Memory copy: channel zero is the source, channel one the target and the count.
    q_addr.push_back(a0 + 16'h1);
    q_addr.push_back(a1);
    q_addr.push_back(a0 + 16'h2);
    q_addr.push_back(a1 + 16'h1);
    q_wd.push_back({4'h5, a0[3:0] + 4'h1});
    q_wd.push_back({4'h5, a0[3:0] + 4'h2});
    host_wr(`FCD_OFF_CMD, 8'h01);
    host_wr(`FCD_OFF_REQ, 8'h04);
    wait_for(1'b1);
    tick(4);
    compare(eop_cnt, 16'h4);
    host_rd(`FCD_OFF_MCLR, {4'h5, a0[3:0] + 4'h2});
    give_verdict();
  end
endmodule

bind fcdma_top fcdma_properties chk_u (.clk_sys, .rst, .ready, .bus_request_out,
  .channel_acknowledge, .host_data_bus_oe, .low_address_lines_oe, .upper_address_strobe,
  .address_latch_enable, .memory_read_strobe_n, .memory_write_strobe_n,
  .end_of_process_line_n_out, .end_of_process_line_n_oe, .io_read_strobe_n_oe,
  .io_read_strobe_n_out, .io_write_strobe_n_oe, .io_write_strobe_n_out);
